// >>> src/ulm_status.sv
// Line status, modem status and upper modem control of one channel
`timescale 1ns/1ps
`default_nettype none
module ulm_status #(
	parameter int RX_DEPTH = ulm_pkg::RX_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	// Host register port
	input wire ulm_pkg::ulm_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	// Receiver side
	input wire logic rx_char_valid_i,
	input wire ulm_pkg::ulm_rx_char_t rx_char_i,
	output logic rx_fifo_ready_o,
	input wire logic rx_xon_i,
	input wire logic rx_xoff_i,
	output logic rx_serial_o,
	// Transmitter side
	input wire logic tx_serial_i,
	input wire logic tx_hold_empty_i,
	input wire logic tsr_empty_i,
	output logic tx_wr_o,
	output logic [7:0] tx_data_o,
	output logic tx_halt_o,
	// Baud timing
	input wire logic bit_tick_i,
	input wire logic samp_tick_i,
	output logic baud_clk_en_o,
	// Pins
	output logic serial_tx_o,
	input wire logic serial_rx_i,
	input wire ulm_pkg::ulm_modem_in_t modem_i,
	output logic rts_n_o,
	output logic dtr_n_o,
	input wire logic ir_strap_i,
	// Interrupt requests
	output logic line_irq_o,
	output logic modem_irq_o
);
	import ulm_pkg::*;
	localparam int CW = $clog2(RX_DEPTH+1);
	localparam int CHW = $bits(ulm_rx_char_t);
	if (RX_DEPTH < 2) begin : g_chk
		$error("ulm_status: RX_DEPTH must be at least 2");
	end
	typedef enum logic [1:0] {
		RS_RECV,
		RS_SEND,
		RS_HOLD
	} ulm_rs_state_t;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic rd_data;
	logic rd_lsr;
	logic rd_msr;
	logic wr_data;
	logic wr_ier;
	logic wr_mcr;
	logic wr_msr;
	logic wr_feature_control_reg;
	logic wr_efr;
	assign rd_data = reg_req_i.rd && reg_req_i.addr == ADDR_DATA;
	assign rd_lsr = reg_req_i.rd && reg_req_i.addr == ADDR_LSR;
	assign rd_msr = reg_req_i.rd && reg_req_i.addr == ADDR_MSR;
	assign wr_data = reg_req_i.wr && reg_req_i.addr == ADDR_DATA;
	assign wr_ier = reg_req_i.wr && reg_req_i.addr == ADDR_IER;
	assign wr_mcr = reg_req_i.wr && reg_req_i.addr == ADDR_MCR;
	assign wr_msr = reg_req_i.wr && reg_req_i.addr == ADDR_MSR;
	assign wr_feature_control_reg = reg_req_i.wr && reg_req_i.addr == ADDR_FEATURE_CONTROL_REG;
	assign wr_efr = reg_req_i.wr && reg_req_i.addr == ADDR_EFR;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic [7:0] ier_q;
	logic [7:0] mcr_q;
	logic [7:0] efr_q;
	logic [7:0] feature_control_reg_q;
	logic [3:0] delay_q;
	logic [7:0] ier_d;
	logic [7:0] mcr_d;
	logic [3:0] delay_d;
	logic enh;
	logic chan_rst;
	assign enh = efr_q[EFR_ENH];
	assign chan_rst = rst_i || soft_rst_i;
	// Upper bits are locked unless enhanced functions are on
	assign ier_d = wr_ier ? {enh ? reg_req_i.wdata[7:4] : ier_q[7:4], reg_req_i.wdata[3:0]} : ier_q;
	assign mcr_d = wr_mcr ? {enh ? reg_req_i.wdata[7:5] : mcr_q[7:5], reg_req_i.wdata[4:0]} : mcr_q;
	assign delay_d = (wr_msr && enh) ? reg_req_i.wdata[7:4] : delay_q;
	always_ff @(posedge sys_clk_i) begin
		if (chan_rst) begin
			ier_q <= IER_RST;
			mcr_q <= {MCR_RST[7], ir_strap_i, MCR_RST[5:0]};
			efr_q <= EFR_RST;
			feature_control_reg_q <= FEATURE_CONTROL_REG_RST;
			delay_q <= DELAY_RST;
		end else begin
			ier_q <= ier_d;
			mcr_q <= mcr_d;
			efr_q <= wr_efr ? reg_req_i.wdata : efr_q;
			feature_control_reg_q <= wr_feature_control_reg ? reg_req_i.wdata : feature_control_reg_q;
			delay_q <= delay_d;
		end
	end

	// ----------------------------------------
	// Receive FIFO and its tags
	// ----------------------------------------
	ulm_rx_char_t head;
	logic rx_valid;
	logic [CW-1:0] rx_count;
	logic push_try;
	logic push_fire;
	logic pop;
	logic overrun_set;
	logic brk_seen_q;
	logic hide_q;
	logic overrun_q;
	logic [CW-1:0] err_cnt_q;
	logic head_err;
	logic char_err;
	assign push_try = rx_char_valid_i && !(rx_char_i.brk && brk_seen_q);
	assign push_fire = push_try && rx_fifo_ready_o;
	assign overrun_set = push_try && !rx_fifo_ready_o;
	assign pop = rd_data && rx_valid;
	assign char_err = rx_char_i.brk || rx_char_i.frm || rx_char_i.par;
	assign head_err = head.brk || head.frm || head.par;
	ulm_fifo #(
		.WIDTH(CHW),
		.DEPTH(RX_DEPTH)
	) u_rx_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_i(chan_rst),
		.in_valid_i(push_try),
		.in_ready_o(rx_fifo_ready_o),
		.in_data_i(rx_char_i),
		.out_valid_o(rx_valid),
		.out_ready_i(rd_data),
		.out_data_o(head),
		.count_o(rx_count)
	);
	always_ff @(posedge sys_clk_i) begin
		if (chan_rst) begin
			brk_seen_q <= 1'b0;
			hide_q <= 1'b0;
			overrun_q <= 1'b0;
			err_cnt_q <= '0;
		end else begin
			// Break stays armed until the line returns to mark
			brk_seen_q <= (rx_char_valid_i && rx_char_i.brk) || (brk_seen_q && !rx_serial_o);
			// read hides head tags until the next head
			hide_q <= pop ? 1'b0 : (hide_q || (rd_lsr && rx_valid));
			// overrun set wins over the clearing read
			overrun_q <= overrun_set || (overrun_q && !rd_lsr);
			err_cnt_q <= err_cnt_q + CW'(push_fire && char_err) - CW'(pop && head_err);
		end
	end

	// ----------------------------------------
	// Transmit status
	// ----------------------------------------
	logic hold_empty_q;
	logic thre_q;
	logic temt;
	always_ff @(posedge sys_clk_i) begin
		if (chan_rst) begin
			hold_empty_q <= 1'b1;
			thre_q <= 1'b1;
			tx_wr_o <= 1'b0;
			tx_data_o <= 8'h00;
		end else begin
			hold_empty_q <= tx_hold_empty_i;
			// host write clears, emptying edge sets
			if (wr_data) begin
				thre_q <= 1'b0;
			end else if (tx_hold_empty_i && !hold_empty_q) begin
				thre_q <= 1'b1;
			end
			tx_wr_o <= wr_data;
			tx_data_o <= wr_data ? reg_req_i.wdata : tx_data_o;
		end
	end
	assign temt = thre_q && tsr_empty_i;

	// ----------------------------------------
	// Line status value
	// ----------------------------------------
	logic [7:0] line_status;
	logic fifo_err;
	logic tag_show;
	assign fifo_err = err_cnt_q != '0;
	assign tag_show = rx_valid && !hide_q;
	assign line_status = {fifo_err, temt, thre_q, tag_show && head.brk, tag_show && head.frm,
		tag_show && head.par, overrun_q, rx_valid};
	assign line_irq_o = ier_q[IER_LSI] && (line_status[4:1] != 4'h0 || fifo_err);

	// ----------------------------------------
	// Modem status
	// ----------------------------------------
	logic loop;
	logic [3:0] stat;
	logic [3:0] stat_q;
	logic [3:0] delta_q;
	logic [3:0] delta_ev;
	assign loop = mcr_q[MCR_LOOP];
	// source selection, order cd ri dsr cts
	assign stat = loop ? {mcr_q[MCR_OUT2], mcr_q[MCR_FSEL], mcr_q[MCR_DTR], mcr_q[MCR_RTS]} : ~modem_i;
	// ring counts only its trailing edge
	assign delta_ev = {stat_q[3] ^ stat[3], stat_q[2] && !stat[2], stat_q[1] ^ stat[1], stat_q[0] ^ stat[0]};
	always_ff @(posedge sys_clk_i) begin
		if (chan_rst) begin
			// Pin levels loaded so an active input gives no false delta after reset
			stat_q <= ~modem_i;
			delta_q <= 4'h0;
		end else begin
			stat_q <= stat;
			// read clears, new change still wins
			delta_q <= (rd_msr ? 4'h0 : delta_q) | delta_ev;
		end
	end
	assign modem_irq_o = ier_q[IER_MSI] && delta_q != 4'h0;

	// ----------------------------------------
	// Flow control
	// ----------------------------------------
	logic xoff_q;
	logic cts_halt;
	always_ff @(posedge sys_clk_i) begin
		if (chan_rst) begin
			xoff_q <= 1'b0;
		end else begin
			xoff_q <= rx_xoff_i || (xoff_q && !rx_xon_i && !(mcr_q[MCR_XANY] && rx_char_valid_i));
		end
	end
	// CTS high reads as status 0
	assign cts_halt = efr_q[EFR_ACTS] && !mcr_q[MCR_FSEL] && !stat[0];
	assign tx_halt_o = xoff_q || cts_halt;

	// ----------------------------------------
	// RS-485 direction
	// ----------------------------------------
	ulm_rs_state_t rs_q;
	ulm_rs_state_t rs_d;
	logic [3:0] hold_cnt_q;
	logic [3:0] hold_cnt_d;
	logic busy;
	assign busy = wr_data || !temt;
	always_comb begin
		rs_d = rs_q;
		hold_cnt_d = hold_cnt_q;
		case (rs_q)
			RS_RECV: begin
				if (busy) begin
					rs_d = RS_SEND;
				end
			end
			RS_SEND: begin
				if (!busy) begin
					rs_d = (delay_q == 4'h0) ? RS_RECV : RS_HOLD;
					hold_cnt_d = 4'h0;
				end
			end
			RS_HOLD: begin
				if (busy) begin
					rs_d = RS_SEND;
				end else if (bit_tick_i) begin
					hold_cnt_d = hold_cnt_q + 4'h1;
					if (4'(hold_cnt_q + 4'h1) == delay_q) begin
						rs_d = RS_RECV;
					end
				end
			end
			default: begin
				rs_d = RS_RECV;
			end
		endcase
	end
	always_ff @(posedge sys_clk_i) begin
		if (chan_rst) begin
			rs_q <= RS_RECV;
			hold_cnt_q <= 4'h0;
		end else begin
			rs_q <= rs_d;
			hold_cnt_q <= hold_cnt_d;
		end
	end
	// loopback parks the modem outputs inactive
	assign rts_n_o = loop || (feature_control_reg_q[FEATURE_CONTROL_REG_485] ? rs_q != RS_RECV : !mcr_q[MCR_RTS]);
	assign dtr_n_o = loop || !mcr_q[MCR_DTR];

	// ----------------------------------------
	// Prescaler and serial path
	// ----------------------------------------
	logic [1:0] presc_q;
	logic phy_rx;
	always_ff @(posedge sys_clk_i) begin
		if (chan_rst) begin
			presc_q <= 2'h0;
		end else begin
			presc_q <= presc_q + 2'h1;
		end
	end
	// one enable in four when divided
	assign baud_clk_en_o = !mcr_q[MCR_PRESC] || presc_q == 2'(PRESC_DIV - 1);
	ulm_irda u_irda (
		.sys_clk_i(sys_clk_i),
		.rst_i(chan_rst),
		.ir_en_i(mcr_q[MCR_IREN]),
		.rx_inv_i(feature_control_reg_q[FEATURE_CONTROL_REG_IRINV]),
		.samp_tick_i(samp_tick_i),
		.tx_serial_i(loop || tx_serial_i),
		.rx_serial_o(phy_rx),
		.serial_tx_o(serial_tx_o),
		.serial_rx_i(serial_rx_i)
	);
	// Loopback bypasses the phy so the encoder latency never reaches the receiver
	assign rx_serial_o = loop ? tx_serial_i : phy_rx;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [7:0] rd_mux;
	assign rd_mux = (reg_req_i.addr == ADDR_DATA) ? (rx_valid ? head.data : 8'h00) :
		(reg_req_i.addr == ADDR_IER) ? ier_q :
		(reg_req_i.addr == ADDR_MCR) ? mcr_q :
		(reg_req_i.addr == ADDR_LSR) ? line_status :
		(reg_req_i.addr == ADDR_MSR) ? {stat, delta_q} :
		(reg_req_i.addr == ADDR_FEATURE_CONTROL_REG) ? feature_control_reg_q :
		(reg_req_i.addr == ADDR_EFR) ? efr_q : 8'h00;
	always_ff @(posedge sys_clk_i) begin
		if (chan_rst) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_req_i.rd) begin
			reg_rdata_o <= rd_mux;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (chan_rst);
	sequence s_full_arrival;
		overrun_set && !pop;
	endsequence
	sequence s_ring_end;
		stat_q[2] && !stat[2] && !loop;
	endsequence
	sequence s_turn_start;
		feature_control_reg_q[FEATURE_CONTROL_REG_485] && !loop && rs_q == RS_SEND && !busy;
	endsequence
	a_overrun_drop: assert property (s_full_arrival |=> $stable(rx_count) && overrun_q)
		else $error("overrun did not drop the character");
	a_lsr_read_clr: assert property (rd_lsr && !overrun_set && !pop && (rx_valid || !push_fire)
		|=> !overrun_q && !line_status[2] && !line_status[3])
		else $error("line status read left error bits set");
	a_data_ready: assert property (line_status[0] == (rx_count != '0))
		else $error("data ready disagrees with FIFO level");
	a_fifo_err_empty: assert property (rx_count == '0 |-> !line_status[7])
		else $error("FIFO error with empty FIFO");
	a_ring_delta: assert property (s_ring_end |=> delta_q[2])
		else $error("ring end not flagged");
	a_msr_read_clr: assert property (rd_msr && delta_ev == 4'h0 |=> delta_q == 4'h0)
		else $error("modem status read left deltas");
	a_loop_mirror: assert property (loop |-> stat == {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} && rts_n_o)
		else $error("loopback mirror wrong");
	a_cts_halt: assert property (efr_q[EFR_ACTS] && !mcr_q[MCR_FSEL] && !loop && modem_i.cts_n |-> tx_halt_o)
		else $error("CTS high did not halt");
	a_rts_hold: assert property ((s_turn_start and (delay_q != 4'h0)) |=> rts_n_o)
		else $error("turnaround delay skipped");
	a_rts_release: assert property ((s_turn_start and (delay_q == 4'h0)) |=> !rts_n_o)
		else $error("RTS not released after last stop");
	a_thre_write: assert property (wr_data |=> !line_status[5] && !line_status[6])
		else $error("holding empty not cleared by write");
	a_temt_thre: assert property (line_status[6] |-> line_status[5])
		else $error("transmitter empty while holding full");
	a_xon_any: assert property (mcr_q[MCR_XANY] && xoff_q && rx_char_valid_i && !rx_xoff_i |=> !xoff_q)
		else $error("xon-any did not resume");
	a_presc_quarter: assert property (mcr_q[MCR_PRESC] && baud_clk_en_o && !wr_mcr |=> !baud_clk_en_o)
		else $error("prescaler enable not divided");
endmodule
`default_nettype wire

// >>> src/ulm_pkg.sv
// Shared constants and carrier types for the line and modem status section
package ulm_pkg;
	// ----------------------------------------
	// Register index map
	// ----------------------------------------
	localparam logic [3:0] ADDR_DATA = 4'h0;
	localparam logic [3:0] ADDR_IER = 4'h1;
	localparam logic [3:0] ADDR_MCR = 4'h4;
	localparam logic [3:0] ADDR_LSR = 4'h5;
	localparam logic [3:0] ADDR_MSR = 4'h6;
	localparam logic [3:0] ADDR_FEATURE_CONTROL_REG = 4'h8;
	localparam logic [3:0] ADDR_EFR = 4'h9;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_FSEL = 2;
	localparam int MCR_OUT2 = 3;
	localparam int MCR_LOOP = 4;
	localparam int MCR_XANY = 5;
	localparam int MCR_IREN = 6;
	localparam int MCR_PRESC = 7;
	localparam int IER_LSI = 2;
	localparam int IER_MSI = 3;
	localparam int EFR_ENH = 4;
	localparam int EFR_ACTS = 7;
	localparam int FEATURE_CONTROL_REG_IRINV = 4;
	localparam int FEATURE_CONTROL_REG_485 = 5;
	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] MCR_RST = 8'h00;
	localparam logic [7:0] IER_RST = 8'h00;
	localparam logic [7:0] EFR_RST = 8'h00;
	localparam logic [7:0] FEATURE_CONTROL_REG_RST = 8'h00;
	localparam logic [3:0] DELAY_RST = 4'h0;
	localparam int RX_FIFO_DEPTH = 16;
	localparam int PRESC_DIV = 4;
	localparam int IR_SAMPLES = 16;
	localparam int IR_PULSE = 3;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic brk;
		logic frm;
		logic par;
		logic [7:0] data;
	} ulm_rx_char_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} ulm_reg_req_t;
	typedef struct packed {
		logic cd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} ulm_modem_in_t;
endpackage

// >>> src/ulm_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ulm_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	// Pointers wrap naturally, so depth must be a power of two
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
		$error("ulm_fifo: DEPTH must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready_o = cnt_q != CW'(DEPTH);
	assign out_valid_o = cnt_q != '0;
	assign out_data_o = mem_q[rp_q];
	assign count_o = cnt_q;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(pop);
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_q[wp_q] <= in_data_i;
		end
	end
endmodule
`default_nettype wire

// >>> src/ulm_irda.sv
// Infrared pulse encoder and decoder on the serial pins
`timescale 1ns/1ps
`default_nettype none
module ulm_irda #(
	parameter int SAMPLES = ulm_pkg::IR_SAMPLES,
	parameter int PULSE = ulm_pkg::IR_PULSE
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Control
	input wire logic ir_en_i,
	input wire logic rx_inv_i,
	input wire logic samp_tick_i,
	// Serial side
	input wire logic tx_serial_i,
	output logic rx_serial_o,
	// Pins
	output logic serial_tx_o,
	input wire logic serial_rx_i
);
	import ulm_pkg::*;
	localparam int PW = $clog2(SAMPLES+1);
	if (PULSE < 1 || PULSE >= SAMPLES) begin : g_chk
		$error("ulm_irda: PULSE must lie between 1 and SAMPLES-1");
	end
	logic tx_prev_q;
	logic [PW-1:0] phase_q;
	logic [PW-1:0] stretch_q;
	logic ir_pulse;
	logic pulse_in;
	// Only the first zero bit of a run sends a short high pulse; a mark sends nothing
	assign ir_pulse = !tx_serial_i && phase_q < PW'(PULSE);
	assign pulse_in = serial_rx_i ^ rx_inv_i;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tx_prev_q <= 1'b1;
			phase_q <= '0;
			stretch_q <= '0;
			serial_tx_o <= 1'b1;
			rx_serial_o <= 1'b1;
		end else begin
			tx_prev_q <= tx_serial_i;
			if (tx_serial_i != tx_prev_q) begin
				phase_q <= '0;
			end else if (samp_tick_i && phase_q != PW'(SAMPLES)) begin
				phase_q <= phase_q + PW'(1);
			end
			if (pulse_in) begin
				stretch_q <= PW'(SAMPLES);
			end else if (samp_tick_i && stretch_q != '0) begin
				stretch_q <= stretch_q - PW'(1);
			end
			serial_tx_o <= ir_en_i ? ir_pulse : tx_serial_i;
			rx_serial_o <= ir_en_i ? (stretch_q == '0 && !pulse_in) : serial_rx_i;
		end
	end
endmodule
`default_nettype wire

// >>> verif/ulm_modem_model.sv
// Modem-side model driving the active-low modem inputs and the serial receive pin
`timescale 1ns/1ps
`default_nettype none
module ulm_modem_model (
	// Clock
	input wire logic sys_clk_i,
	// Commanded levels
	input wire ulm_pkg::ulm_modem_in_t want_i,
	// Pins toward the channel
	output ulm_pkg::ulm_modem_in_t modem_o,
	output logic serial_rx_o
);
	import ulm_pkg::*;
	// Levels change only just after an edge, as a real modem would settle
	initial modem_o = '1;
	always @(posedge sys_clk_i) begin
		modem_o <= want_i;
	end
	// Line idles at mark between frames
	assign serial_rx_o = 1'b1;
endmodule
`default_nettype wire

// >>> verif/test_ulm_status.sv
// Self-checking bench for the line and modem status section
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH %0t %s", $time, m); end end
module test_ulm_status;
	import ulm_pkg::*;
	logic sys_clk_i = 0, rst_i = 1, soft_rst_i = 0, rx_valid = 0, strap = 1;
	ulm_reg_req_t req = '0;
	ulm_rx_char_t rx_char = '0;
	ulm_modem_in_t want = '1, modem;
	logic serial_rx, rx_rdy, tx_pin, baud_en, rts_n, dtr_n, line_irq, modem_irq;
	logic rx_ser, tx_wr, tx_halt;
	logic tx_ser = 1, hold_empty = 1, tsr_empty = 1, bit_tick = 0;
	logic [7:0] rdata, d, tx_data;
	int fail_count = 0, tests_run = 0, n;
	always #10 sys_clk_i = ~sys_clk_i;
	ulm_modem_model peer (.sys_clk_i(sys_clk_i), .want_i(want), .modem_o(modem), .serial_rx_o(serial_rx));
	ulm_status dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .rx_char_valid_i(rx_valid), .rx_char_i(rx_char), .rx_fifo_ready_o(rx_rdy),
		.rx_xon_i(1'b0), .rx_xoff_i(1'b0), .rx_serial_o(rx_ser), .tx_serial_i(tx_ser),
		.tx_hold_empty_i(hold_empty), .tsr_empty_i(tsr_empty), .tx_wr_o(tx_wr), .tx_data_o(tx_data),
		.tx_halt_o(tx_halt), .bit_tick_i(bit_tick), .samp_tick_i(1'b0), .baud_clk_en_o(baud_en),
		.serial_tx_o(tx_pin), .serial_rx_i(serial_rx), .modem_i(modem), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
		.ir_strap_i(strap), .line_irq_o(line_irq), .modem_irq_o(modem_irq));
	// ----------------------------------------
	// Register port and stream tasks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk_i) req <= '{1'b1, 1'b0, a, v};
		@(posedge sys_clk_i) req <= '0;
	endtask
	// Read data is sampled once the edge after the strobe has landed
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge sys_clk_i) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk_i) req <= '0;
		#1 v = rdata;
	endtask
	task automatic push(input int cnt, input logic par);
		repeat (cnt) @(posedge sys_clk_i) begin
			rx_valid <= 1'b1;
			rx_char <= '{1'b0, 1'b0, par, 8'h5a};
		end
		@(posedge sys_clk_i) rx_valid <= 1'b0;
		#1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(ADDR_LSR, d); `CHK(d, 8'h60, "line status after reset")
		rd(ADDR_MCR, d); `CHK(d, 8'h40, "strap into infrared enable")
		`CHK({rts_n, dtr_n}, 2'b11, "modem outputs inactive")
		repeat (4) @(posedge sys_clk_i);
		#1 `CHK(tx_pin, 1'b0, "infrared output idles low")
	endtask
	task automatic t_presc;
		// Enhanced functions enabled first so upper control bits are accepted
		wr(ADDR_EFR, 8'h10);
		foreach (d[i]) if (i < 2) begin
			wr(ADDR_MCR, i ? 8'hc0 : 8'h40);
			n = 0;
			repeat (8) @(posedge sys_clk_i) #1 n += (baud_en === 1'b1);
			`CHK(n, i ? 8 / PRESC_DIV : 8, "baud enable rate")
		end
	endtask
	task automatic t_rx;
		wr(ADDR_IER, 8'h0c);
		push(1, 1'b1);
		`CHK(line_irq, 1'b1, "line interrupt on error char")
		rd(ADDR_LSR, d); `CHK(d, 8'he5, "ready, parity, fifo error")
		rd(ADDR_LSR, d); `CHK(d, 8'he1, "bits 4-1 cleared by read")
		rd(ADDR_DATA, d); `CHK(d, 8'h5a, "received byte")
		rd(ADDR_LSR, d); `CHK(d, 8'h60, "empty fifo, error flag gone")
		// One past the depth must be dropped without disturbing the queue
		push(RX_FIFO_DEPTH + 1, 1'b0);
		`CHK(rx_rdy, 1'b0, "fifo full")
		rd(ADDR_LSR, d); `CHK(d, 8'h63, "overrun flagged")
		repeat (RX_FIFO_DEPTH) rd(ADDR_DATA, d);
		rd(ADDR_LSR, d); `CHK(d, 8'h60, "exactly depth chars kept")
		// A read of an empty FIFO must not hide the tags of the next arrival
		push(1, 1'b1);
		rd(ADDR_LSR, d); `CHK(d, 8'he5, "tag of char after empty read")
		rd(ADDR_DATA, d);
	endtask
	task automatic t_tx;
		wr(ADDR_FEATURE_CONTROL_REG, 8'h20);
		wr(ADDR_MSR, 8'h20);
		wr(ADDR_DATA, 8'h3c);
		#1 `CHK({tx_wr, tx_data, rts_n}, {1'b1, 8'h3c, 1'b1}, "byte handed over, RTS turned")
		@(posedge sys_clk_i) begin
			hold_empty <= 1'b0;
			tsr_empty <= 1'b0;
		end
		@(posedge sys_clk_i) hold_empty <= 1'b1;
		rd(ADDR_LSR, d); `CHK(d, 8'h20, "holding empty, shift busy")
		@(posedge sys_clk_i) tsr_empty <= 1'b1;
		repeat (2) begin
			@(posedge sys_clk_i) bit_tick <= 1'b1;
			#1 `CHK(rts_n, 1'b1, "RTS held during turnaround delay")
			@(posedge sys_clk_i) bit_tick <= 1'b0;
		end
		#1 `CHK(rts_n, 1'b0, "RTS released after delay")
		rd(ADDR_LSR, d); `CHK(d, 8'h60, "transmitter empty")
	endtask
	task automatic t_modem;
		rd(ADDR_MSR, d);
		wr(ADDR_EFR, 8'h90);
		#1 `CHK(tx_halt, 1'b1, "CTS high halts transmitter")
		want.cts_n = 1'b0;
		repeat (4) @(posedge sys_clk_i);
		#1 `CHK(modem_irq, 1'b1, "modem interrupt")
		`CHK(tx_halt, 1'b0, "CTS low resumes transmitter")
		rd(ADDR_MSR, d); `CHK(d, 8'h11, "cts delta and inverted level")
		rd(ADDR_MSR, d); `CHK(d, 8'h10, "deltas cleared by read")
		want.ri_n = 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rd(ADDR_MSR, d); `CHK(d, 8'h50, "no ring delta on falling edge")
		want.ri_n = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		rd(ADDR_MSR, d); `CHK(d, 8'h14, "ring delta on rising edge")
	endtask
	task automatic t_loop;
		wr(ADDR_MCR, 8'h55);
		rd(ADDR_MSR, d); `CHK(d[7:4], 4'h6, "loopback mirror")
		`CHK({rts_n, dtr_n}, 2'b11, "pins inactive in loopback")
		@(posedge sys_clk_i) tx_ser <= 1'b0;
		#1 `CHK(rx_ser, 1'b0, "transmit line looped to receiver")
		@(posedge sys_clk_i) begin
			tx_ser <= 1'b1;
			strap <= 1'b0;
			soft_rst_i <= 1'b1;
		end
		@(posedge sys_clk_i) soft_rst_i <= 1'b0;
		rd(ADDR_MCR, d); `CHK(d, 8'h00, "strap resampled by soft reset")
	endtask
	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task automatic end_of_test;
		if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_presc;
		t_rx;
		t_tx;
		t_modem;
		t_loop;
		end_of_test;
	end
	// Whole run is under two hundred cycles; this leaves wide margin
	initial begin
		#200000;
		fail_count++;
		end_of_test;
	end
endmodule
`default_nettype wire
